// ---- logic/mxadc_map.vh ----
// mxadc_map.vh: register offsets, field positions, reset values and codes
// assumes inclusion by bare name from the design files under logic/
`ifndef MXADC_MAP_VH
`define MXADC_MAP_VH

// register offsets on the plain register port
`define MXADC_ADDR_W          8
`define MXADC_OFS_GAIN_TRIM   8'h8_F
`define MXADC_OFS_STEP0       8'h9_0
`define MXADC_OFS_STEP1       8'h9_1
`define MXADC_OFS_SEQ_CTRL    8'hA_0
`define MXADC_OFS_SEQ_STAT    8'hA_1

// reset values
`define MXADC_RST_STEP0       16'h0000
`define MXADC_RST_STEP1       16'h0001
`define MXADC_RST_GAIN_TRIM   16'h0000
`define MXADC_RST_SEQ_CTRL    16'h0000

// step configuration fields
`define MXADC_EN_BIT          15
`define MXADC_GAIN_HI         14
`define MXADC_GAIN_LO         13
`define MXADC_NEG_BIT         4
`define MXADC_POS_HI          3
`define MXADC_POS_LO          0
`define MXADC_STEP_WMASK      16'hE01F

// control register fields
`define MXADC_CTL_START_BIT   0
`define MXADC_CTL_DLY_HI      10
`define MXADC_CTL_DLY_LO      8

// gain codes as handed to the converter; both upper codes mean gain 4
`define MXADC_GAIN_X1         2'h0
`define MXADC_GAIN_X2         2'h1
`define MXADC_GAIN_X4         2'h2

// positive input codes
`define MXADC_POS_TEMP        4'h8
`define MXADC_POS_SHORT       4'h9
`define MXADC_POS_ARAIL       4'hE
`define MXADC_POS_DRAIL       4'hF

// negative input selections presented to the analog mux
`define MXADC_NEG_AGND        2'h0
`define MXADC_NEG_EXT7        2'h1
`define MXADC_NEG_AUTO        2'h2

// settling delays in modulator clocks, one per delay select code
`define MXADC_DLY_16          13'h0010
`define MXADC_DLY_64          13'h0040
`define MXADC_DLY_128         13'h0080
`define MXADC_DLY_256         13'h0100
`define MXADC_DLY_512         13'h0200
`define MXADC_DLY_1024        13'h0400
`define MXADC_DLY_2048        13'h0800
`define MXADC_DLY_4096        13'h1000

`endif

// ---- logic/mxadc_gain_trim.v ----
// mxadc_gain_trim.v: applies the signed gain trim word to a converter result
// assumes a signed result and a trim word that are stable for one cycle
`timescale 1ns/100ps
`include "mxadc_map.vh"

module mxadc_gain_trim #(
	parameter DATA_W = 16
) (
	input  wire                      mclk,
	input  wire                      reset_n,
	input  wire                      in_valid,
	input  wire signed [DATA_W-1:0]  in_data,
	input  wire signed [15:0]        trim_word,
	output reg                       out_valid_q,
	output reg  signed [DATA_W-1:0]  out_data_q
);

	// product of result and trim word, sized for the full signed range
	wire signed [DATA_W+15:0] prod;
	wire signed [DATA_W+16:0] sum;
	wire signed [DATA_W-1:0]  trimmed_d;

	// RQ1 one plus trim over 2^16
	assign prod = in_data * trim_word;
	// RQ2 one code is 2^-16
	assign sum       = {{1{in_data[DATA_W-1]}}, in_data, 16'h0000} + {prod[DATA_W+15], prod};
	assign trimmed_d = sum[DATA_W+15:16];

	// registered output; truncation toward minus infinity keeps the path short
	always @(posedge mclk) begin
		if (!reset_n) begin
			out_valid_q <= 1'b0;
			out_data_q  <= {DATA_W{1'b0}};
		end else begin
			out_valid_q <= in_valid;
			if (in_valid) begin
				out_data_q <= trimmed_d;
			end
		end
	end

endmodule // mxadc_gain_trim

// ---- logic/mxadc_step_cfg.v ----
// Contract
// RQ1 - the gain trim word is signed and scales a result by one plus the word over 65536.
// RQ2 - the trim word is sixteen bits, one code is 0.000015, zero gives unity gain.
// RQ3 - bit 15 of a step word enables that step for the sequencer.
// RQ4 - bits 14:13 select gain 1, 2, or 4 for codes 00, 01 and 1x.
// RQ5 - bit 4 selects analog ground or external input seven as negative input.
// RQ6 - bits 3:0 codes 0 to 7 route external inputs zero to seven to the positive input.
// RQ7 - positive codes 8 and above pick the negative input automatically and ignore bit 4.
// RQ8 - codes 8, 9, 14 and 15 pick temperature sensor, ground short, and two rail dividers.
// RQ9 - bits 12:5 of a step word are reserved and read as zero.
// RQ10 - step 0 lives at 90h resetting to 0000h and step 1 at 91h resetting to 0001h.
// RQ11 - each step waits a settling delay of 16 to 4096 modulator clocks before converting.
// RQ12 - a disabled step is skipped and produces no conversion result.
//
// mxadc_step_cfg.v: step configuration, gain trim and a two-step sequencer
// assumes a converter that takes conv_start and answers with one conv_done pulse
// limitation: two steps only; the step index is one bit wide
// the converter and the register port run on mclk, so no input is synchronised
`timescale 1ns/100ps
`include "mxadc_map.vh"

module mxadc_step_cfg #(
	parameter DATA_W = 16
) (
	input  wire                      mclk,
	input  wire                      reset_n,
	input  wire [`MXADC_ADDR_W-1:0]  reg_addr,
	input  wire [15:0]               reg_wdata,
	input  wire                      reg_wr,
	input  wire                      reg_rd,
	output reg  [15:0]               reg_rdata_q,
	output reg                       conv_start_q,
	output reg  [1:0]                conv_gain_q,
	output reg  [3:0]                pos_sel_q,
	output reg  [1:0]                neg_sel_q,
	output reg                       conv_step_q,
	input  wire                      conv_done,
	input  wire signed [DATA_W-1:0]  conv_data,
	output wire                      result_valid,
	output wire signed [DATA_W-1:0]  result_data,
	output reg                       result_step_q,
	output reg                       seq_busy_q
);

	// sequencer states
	localparam ST_IDLE   = 3'h0;
	localparam ST_SELECT = 3'h1;
	localparam ST_SETTLE = 3'h2;
	localparam ST_CONV   = 3'h3;
	localparam ST_NEXT   = 3'h4;
	localparam NSTEP     = 2;
	localparam LAST_IDX  = NSTEP - 1;

	// register storage
	// reserved step bits are never stored, so readback cannot expose them
	reg [15:0] step_cfg_q [0:NSTEP-1];
	reg [15:0] gain_trim_q;
	reg [2:0]  dly_sel_q;
	reg        start_req_q;
	reg        done_flag_q;

	// sequencer state
	reg [2:0]  state_q;
	reg [2:0]  state_d;
	reg        step_idx_q;
	reg [12:0] dly_cnt_q;
	reg [15:0] cur_cfg;

	wire wr_step0;
	wire wr_step1;
	wire wr_trim;
	wire wr_ctrl;
	wire start_pulse;
	wire settle_done;
	wire [12:0] dly_len;
	wire        abort_req;
	wire        last_step;
	wire        conv_accept;
	wire [15:0] ctrl_view;
	wire [15:0] stat_view;

	// RQ9 reserved bits read zero
	function [15:0] step_view;
		input [15:0] raw;
		begin
			step_view = raw & `MXADC_STEP_WMASK;
		end
	endfunction

	// RQ4 gain code normalised
	function [1:0] gain_norm;
		input [1:0] code;
		begin
			case (code)
				`MXADC_GAIN_X1: gain_norm = `MXADC_GAIN_X1;
				`MXADC_GAIN_X2: gain_norm = `MXADC_GAIN_X2;
				default:        gain_norm = `MXADC_GAIN_X4;
			endcase
		end
	endfunction

	// RQ11 settle length table
	function [12:0] settle_len;
		input [2:0] sel;
		begin
			case (sel)
				3'h0:    settle_len = `MXADC_DLY_16;
				3'h1:    settle_len = `MXADC_DLY_64;
				3'h2:    settle_len = `MXADC_DLY_128;
				3'h3:    settle_len = `MXADC_DLY_256;
				3'h4:    settle_len = `MXADC_DLY_512;
				3'h5:    settle_len = `MXADC_DLY_1024;
				3'h6:    settle_len = `MXADC_DLY_2048;
				default: settle_len = `MXADC_DLY_4096;
			endcase
		end
	endfunction

	// RQ7 internal source codes
	function pos_internal;
		input [3:0] code;
		begin
			pos_internal = (code >= `MXADC_POS_TEMP);
		end
	endfunction

	// write decode
	assign wr_step0    = reg_wr && (reg_addr == `MXADC_OFS_STEP0);
	assign wr_step1    = reg_wr && (reg_addr == `MXADC_OFS_STEP1);
	assign wr_trim     = reg_wr && (reg_addr == `MXADC_OFS_GAIN_TRIM);
	assign wr_ctrl     = reg_wr && (reg_addr == `MXADC_OFS_SEQ_CTRL);
	assign start_pulse = wr_ctrl && reg_wdata[`MXADC_CTL_START_BIT];

	// a start while busy aborts; the held request then restarts from step 0,
	// so software never has to wait for idle before changing the steps
	assign abort_req   = start_pulse && (state_q != ST_IDLE);
	assign last_step   = (step_idx_q == LAST_IDX[0]);
	// a done pulse outside a conversion is ignored, so a late converter
	// answer after an abort cannot leak a result
	assign conv_accept = conv_done && (state_q == ST_CONV);

	// readback views of control and status; the start bit always reads zero
	assign ctrl_view   = {5'h00, dly_sel_q, 8'h00};
	assign stat_view   = {13'h0000, done_flag_q, step_idx_q, seq_busy_q};

	// RQ10 step words reset values
	always @(posedge mclk) begin
		if (!reset_n) begin
			step_cfg_q[0] <= `MXADC_RST_STEP0;
			step_cfg_q[1] <= `MXADC_RST_STEP1;
			gain_trim_q   <= `MXADC_RST_GAIN_TRIM;
			dly_sel_q     <= 3'h0;
		end else begin
			// only writable fields are stored; reserved bits stay zero
			if (wr_step0) begin
				step_cfg_q[0] <= step_view(reg_wdata);
			end
			if (wr_step1) begin
				step_cfg_q[1] <= step_view(reg_wdata);
			end
			if (wr_trim) begin
				gain_trim_q <= reg_wdata;
			end
			if (wr_ctrl) begin
				dly_sel_q <= reg_wdata[`MXADC_CTL_DLY_HI:`MXADC_CTL_DLY_LO];
			end
		end
	end

	// read mux: data stand in the cycle after the read strobe, unmapped reads zero
	// one registered port keeps the read path off the sequencer timing
	always @(posedge mclk) begin
		if (!reset_n) begin
			reg_rdata_q <= 16'h0000;
		end else if (reg_rd) begin
			case (reg_addr)
				`MXADC_OFS_STEP0:     reg_rdata_q <= step_view(step_cfg_q[0]);
				`MXADC_OFS_STEP1:     reg_rdata_q <= step_view(step_cfg_q[1]);
				`MXADC_OFS_GAIN_TRIM: reg_rdata_q <= gain_trim_q;
				`MXADC_OFS_SEQ_CTRL:  reg_rdata_q <= ctrl_view;
				`MXADC_OFS_SEQ_STAT:  reg_rdata_q <= stat_view;
				default:              reg_rdata_q <= 16'h0000;
			endcase
		end else begin
			reg_rdata_q <= 16'h0000;
		end
	end

	// a start request is held until the sequencer samples it in idle
	// the set wins over the idle clear, so a start is never lost
	always @(posedge mclk) begin
		if (!reset_n) begin
			start_req_q <= 1'b0;
		end else if (start_pulse) begin
			start_req_q <= 1'b1;
		end else if (state_q == ST_IDLE) begin
			start_req_q <= 1'b0;
		end
	end

	// RQ11 delay from select
	assign dly_len     = settle_len(dly_sel_q);
	assign settle_done = (dly_cnt_q == 13'h0001);

	// RQ11 settle counter
	// loaded on select and run down while settling, so settling lasts the full count
	always @(posedge mclk) begin
		if (!reset_n) begin
			dly_cnt_q <= 13'h0000;
		end else if (state_q == ST_SELECT) begin
			dly_cnt_q <= dly_len;
		end else if (state_q == ST_SETTLE) begin
			dly_cnt_q <= dly_cnt_q - 13'h0001;
		end
	end

	// current step word
	always @* begin
		cur_cfg = step_cfg_q[step_idx_q];
	end

	// sequencer next state
	always @* begin
		state_d = state_q;
		case (state_q)
			ST_IDLE: begin
				if (start_req_q) begin
					state_d = ST_SELECT;
				end
			end
			ST_SELECT: begin
				// RQ12 skip a disabled step
				if (cur_cfg[`MXADC_EN_BIT]) begin
					state_d = ST_SETTLE;
				end else begin
					state_d = ST_NEXT;
				end
			end
			ST_SETTLE: begin
				if (settle_done) begin
					state_d = ST_CONV;
				end
			end
			ST_CONV: begin
				if (conv_done) begin
					state_d = ST_NEXT;
				end
			end
			ST_NEXT: begin
				if (last_step) begin
					state_d = ST_IDLE;
				end else begin
					state_d = ST_SELECT;
				end
			end
			default: state_d = ST_IDLE;
		endcase
	end

	// sequencer registers; a start during a sequence aborts it to idle,
	// and the held start request begins a fresh sequence one cycle later
	always @(posedge mclk) begin
		if (!reset_n) begin
			state_q      <= ST_IDLE;
			step_idx_q   <= 1'b0;
			conv_start_q <= 1'b0;
			seq_busy_q   <= 1'b0;
			done_flag_q  <= 1'b0;
		end else begin
			conv_start_q <= 1'b0;
			if (abort_req) begin
				state_q    <= ST_IDLE;
				step_idx_q <= 1'b0;
				seq_busy_q <= 1'b0;
			end else begin
				state_q <= state_d;
				if (state_q == ST_IDLE && start_req_q) begin
					step_idx_q  <= 1'b0;
					seq_busy_q  <= 1'b1;
					done_flag_q <= 1'b0;
				end
				// RQ11 convert once settled
				if (state_q == ST_SETTLE && settle_done) begin
					conv_start_q <= 1'b1;
				end
				if (state_q == ST_NEXT) begin
					if (last_step) begin
						seq_busy_q  <= 1'b0;
						done_flag_q <= 1'b1;
					end else begin
						step_idx_q <= step_idx_q + 1'b1;
					end
				end
			end
		end
	end

	// analog selections for the step in progress, latched on selection
	// a disabled step leaves the previous selections standing; the analog
	// side only looks at them around the conversion start
	always @(posedge mclk) begin
		if (!reset_n) begin
			conv_gain_q <= `MXADC_GAIN_X1;
			pos_sel_q   <= 4'h0;
			neg_sel_q   <= `MXADC_NEG_AGND;
			conv_step_q <= 1'b0;
		end else if (state_q == ST_SELECT) begin
			// RQ3 enabled step only
			if (cur_cfg[`MXADC_EN_BIT]) begin
				// RQ4 gain code to converter
				conv_gain_q <= gain_norm(cur_cfg[`MXADC_GAIN_HI:`MXADC_GAIN_LO]);
				// RQ6 RQ8 positive routing
				pos_sel_q   <= cur_cfg[`MXADC_POS_HI:`MXADC_POS_LO];
				conv_step_q <= step_idx_q;
				// RQ7 automatic negative input
				if (pos_internal(cur_cfg[`MXADC_POS_HI:`MXADC_POS_LO])) begin
					neg_sel_q <= `MXADC_NEG_AUTO;
				// RQ5 negative select bit
				end else if (cur_cfg[`MXADC_NEG_BIT]) begin
					neg_sel_q <= `MXADC_NEG_EXT7;
				end else begin
					neg_sel_q <= `MXADC_NEG_AGND;
				end
			end
		end
	end

	// result step tag has the same one cycle of latency as the trim stage
	// it is taken with the accepted done pulse, so it pairs with result_valid
	always @(posedge mclk) begin
		if (!reset_n) begin
			result_step_q <= 1'b0;
		end else if (conv_accept) begin
			result_step_q <= conv_step_q;
		end
	end

	// RQ1 trim applied to results
	// the stage adds one register, matched by the step tag above
	mxadc_gain_trim #(
		.DATA_W (DATA_W)
	) u_trim (
		.mclk        (mclk),
		.reset_n     (reset_n),
		.in_valid    (conv_accept),
		.in_data     (conv_data),
		.trim_word   (gain_trim_q),
		.out_valid_q (result_valid),
		.out_data_q  (result_data)
	);

endmodule // mxadc_step_cfg

// ---- dv/mxadc_step_cfg_assertions.sv ----
// mxadc_step_cfg_assertions.sv: port checks on the step configuration block
// assumes one clock mclk and synchronous active-low reset_n
`timescale 1ns/100ps

module mxadc_step_cfg_chk (
	input wire        mclk,
	input wire        reset_n,
	input wire [7:0]  reg_addr,
	input wire        reg_rd,
	input wire [15:0] reg_rdata_q,
	input wire        conv_start_q,
	input wire [3:0]  pos_sel_q,
	input wire [1:0]  neg_sel_q,
	input wire        conv_done,
	input wire        result_valid,
	input wire        seq_busy_q
);
	// one clock domain, so one default clock and reset
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!reset_n);

	// read data stands only in the cycle after a read
	AST_RD_IDLE: assert property (!$past(reg_rd) |-> reg_rdata_q == 16'h0)
		else $error("read data not zero outside a read");
	AST_RD_RSV: assert property ($past(reg_rd) && $past(reg_addr[7:1]) == 7'h48
		|-> reg_rdata_q[12:5] == 8'h00) else $error("reserved step bits not zero");
	AST_START_PULSE: assert property (conv_start_q |=> !conv_start_q)
		else $error("conversion start longer than one cycle");
	AST_START_BUSY: assert property (conv_start_q |-> seq_busy_q)
		else $error("conversion start outside a sequence");
	AST_AUTO_NEG: assert property (conv_start_q && pos_sel_q[3] |-> neg_sel_q == 2'h2)
		else $error("internal source without automatic negative input");
	AST_EXT_NEG: assert property (conv_start_q && !pos_sel_q[3] |-> !neg_sel_q[1])
		else $error("external input with automatic negative input");
	AST_RES_DONE: assert property (result_valid |-> $past(conv_done))
		else $error("result without a converter done pulse");
	// settling takes at least sixteen cycles, so no start in the first eight
	AST_SETTLE: assert property ($rose(seq_busy_q) |-> !conv_start_q [*8])
		else $error("conversion started before settling");

	cover property (conv_start_q && pos_sel_q[3]);
	cover property (result_valid && $past(conv_done));
	cover property ($fell(seq_busy_q));
endmodule // mxadc_step_cfg_chk

bind mxadc_step_cfg mxadc_step_cfg_chk u_chk (
	.mclk(mclk), .reset_n(reset_n), .reg_addr(reg_addr), .reg_rd(reg_rd),
	.reg_rdata_q(reg_rdata_q), .conv_start_q(conv_start_q), .pos_sel_q(pos_sel_q),
	.neg_sel_q(neg_sel_q), .conv_done(conv_done), .result_valid(result_valid),
	.seq_busy_q(seq_busy_q)
);

// ---- dv/tb_mux_adc_step_config_gain_cal.sv ----
// tb_mux_adc_step_config_gain_cal.sv: register and sequencer tests
// assumes the design and its map header on the include path
`timescale 1ns/100ps
`include "mxadc_map.vh"

module tb_mux_adc_step_config_gain_cal;
	reg               mclk = 0;
	reg               reset_n = 0;
	reg  [7:0]        reg_addr = 8'h00;
	reg  [15:0]       reg_wdata = 16'h0000;
	reg               reg_wr = 0;
	reg               reg_rd = 0;
	reg               conv_done = 0;
	reg  signed [15:0] conv_data = 16'h0000;
	wire [15:0]       reg_rdata_q;
	wire              conv_start_q, conv_step_q, result_valid, result_step_q, seq_busy_q;
	wire [1:0]        conv_gain_q, neg_sel_q;
	wire [3:0]        pos_sel_q;
	wire signed [15:0] result_data;
	integer           errors = 0;
	integer           checked = 0;
	integer           waited = 0;

	always #2.5 mclk = ~mclk;

	mxadc_step_cfg #(.DATA_W(16)) dut (
		.mclk(mclk), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_q(reg_rdata_q),
		.conv_start_q(conv_start_q), .conv_gain_q(conv_gain_q), .pos_sel_q(pos_sel_q),
		.neg_sel_q(neg_sel_q), .conv_step_q(conv_step_q), .conv_done(conv_done),
		.conv_data(conv_data), .result_valid(result_valid), .result_data(result_data),
		.result_step_q(result_step_q), .seq_busy_q(seq_busy_q)
	);

	task cmp(input [15:0] g, input [15:0] e);
		begin
			checked = checked + 1;
			if (g !== e) begin
				errors = errors + 1;
				$display("[FAIL] t=%0t got %h exp %h", $time, g, e);
			end
		end
	endtask

	// one-cycle strobes, driven just after the edge
	task wr(input [7:0] a, input [15:0] d);
		begin
			@(posedge mclk); reg_wr <= 1; reg_addr <= a; reg_wdata <= d;
			@(posedge mclk); reg_wr <= 0;
		end
	endtask

	task rd(input [7:0] a, input [15:0] e);
		begin
			@(posedge mclk); reg_rd <= 1; reg_addr <= a;
			@(posedge mclk); reg_rd <= 0; #1;
			cmp(reg_rdata_q, e);
		end
	endtask

	// e packs step, gain code, positive and negative selections
	task step(input [8:0] e, input [15:0] d, input [15:0] r);
		integer i;
		begin
			i = 0;
			while (conv_start_q !== 1'b1 && i < 5000) begin @(posedge mclk); #1; i = i + 1; end
			waited = i;
			cmp({15'h0, conv_start_q}, 16'h0001);
			cmp({7'h0, conv_step_q, conv_gain_q, pos_sel_q, neg_sel_q}, {7'h0, e});
			@(posedge mclk); conv_done <= 1; conv_data <= d;
			@(posedge mclk); conv_done <= 0; #1;
			i = 0;
			while (result_valid !== 1'b1 && i < 4) begin @(posedge mclk); #1; i = i + 1; end
			cmp({15'h0, result_valid}, 16'h0001);
			cmp(result_data, r);
			cmp({15'h0, result_step_q}, {15'h0, e[8]});
		end
	endtask

	task idle_chk;
		integer i;
		begin
			i = 0;
			while (seq_busy_q !== 1'b0 && i < 100) begin @(posedge mclk); #1; i = i + 1; end
			cmp({15'h0, seq_busy_q}, 16'h0);
		end
	endtask

	task give_verdict;
		begin
			$display("comparisons %0d mismatches %0d", checked, errors);
			if (errors == 0 && checked > 0)
				$display("ALL TESTS PASSED");
			else
				$display("TESTS FAILED");
			$finish;
		end
	endtask

	// a hang cuts the run short after far more than the tests need
	initial begin
		#50000;
		errors = errors + 1;
		give_verdict;
	end

	initial begin
		repeat (12) @(posedge mclk);
		reset_n <= 1;
		rd(`MXADC_OFS_GAIN_TRIM, 16'h0000);
		rd(`MXADC_OFS_STEP0, 16'h0000);
		rd(`MXADC_OFS_STEP1, 16'h0001);
		rd(8'h55, 16'h0000);
		$display("test reset values done");
		wr(`MXADC_OFS_STEP0, 16'hffff);
		rd(`MXADC_OFS_STEP0, 16'he01f);
		wr(`MXADC_OFS_GAIN_TRIM, 16'h8000);
		rd(`MXADC_OFS_GAIN_TRIM, 16'h8000);
		$display("test field access done");
		wr(`MXADC_OFS_GAIN_TRIM, 16'h7fff);
		wr(`MXADC_OFS_STEP0, 16'ha013);
		wr(`MXADC_OFS_STEP1, 16'hc018);
		wr(`MXADC_OFS_SEQ_CTRL, 16'h0001);
		step({1'b0, 2'h1, 4'h3, 2'h1}, 16'h1000, 16'h17ff);
		cmp(waited[15:0], 16'h0012);
		step({1'b1, 2'h2, 4'h8, 2'h2}, 16'hf000, 16'he800);
		idle_chk;
		$display("test two steps done");
		wr(`MXADC_OFS_GAIN_TRIM, 16'h8000);
		wr(`MXADC_OFS_STEP0, 16'h0005);
		wr(`MXADC_OFS_STEP1, 16'h800f);
		wr(`MXADC_OFS_SEQ_CTRL, 16'h0001);
		step({1'b1, 2'h0, 4'hf, 2'h2}, 16'h1000, 16'h0800);
		idle_chk;
		$display("test skipped step done");
		wr(`MXADC_OFS_STEP0, 16'he002);
		wr(`MXADC_OFS_STEP1, 16'h0001);
		wr(`MXADC_OFS_SEQ_CTRL, 16'h0701);
		repeat (10) @(posedge mclk);
		wr(`MXADC_OFS_SEQ_CTRL, 16'h0701);
		step({1'b0, 2'h2, 4'h2, 2'h0}, 16'h0100, 16'h0080);
		cmp(waited[15:0], 16'h1002);
		idle_chk;
		rd(`MXADC_OFS_SEQ_STAT, 16'h0006);
		rd(`MXADC_OFS_SEQ_CTRL, 16'h0700);
		$display("test long settle and restart done");
		give_verdict;
	end
endmodule // tb_mux_adc_step_config_gain_cal
